// *** pkg/sfps_pkg.sv ***
// Purpose: types of the page program sequencer
// Assumes: nothing
// Notes:   constants live in sfps_regs.svh
package sfps_pkg;

    typedef enum logic [2:0] {
        SFPS_IDLE = 3'b000,
        SFPS_INS  = 3'b001,
        SFPS_ADR  = 3'b010,
        SFPS_DAT  = 3'b011,
        SFPS_RX   = 3'b100,
        SFPS_DONE = 3'b101
    } sfps_state_type;

    typedef struct packed {
        logic [7:0] ins;
        logic [8:0] cnt;
    } sfps_cmd_type;

    typedef struct packed {
        logic       lp_ack;
        logic       rx_ne;
        logic       tx_full;
        logic       busy;
    } sfps_status_type;

endpackage

// *** pkg/sfps_regs.svh ***
// Purpose: register offsets, field positions, reset values and counts of the page program sequencer
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes:   definitions only
`ifndef SFPS_REGS_SVH
`define SFPS_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SFPS_OFF_ADDR      8'h00
`define SFPS_OFF_CMD       8'h04
`define SFPS_OFF_TXPORT    8'h08
`define SFPS_OFF_RXPORT    8'h0C
`define SFPS_OFF_STATUS    8'h10
`define SFPS_OFF_FLAG      8'h14
`define SFPS_OFF_IRQ_MASK  8'h18
`define SFPS_OFF_LP_CTRL   8'h1C

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define SFPS_CMD_CNT_LSB   16
`define SFPS_FLAG_RX_BUFFER_NOT_EMPTY_FLAG_BIT 16
`define SFPS_ST_BUSY_BIT   0
`define SFPS_ST_TX_BUFFER_FULL_FLAG_BIT 1
`define SFPS_ST_RX_BUFFER_NOT_EMPTY_FLAG_BIT   2
`define SFPS_ST_LPACK_BIT  3

// ----------------------------------------------------------------
// instruction codes, sizes, reset values
// ----------------------------------------------------------------
`define SFPS_INS_WREN      8'h06
`define SFPS_INS_PP        8'h02
`define SFPS_INS_QPP       8'h32
`define SFPS_INS_RDSR      8'h05
`define SFPS_INS_WRSR      8'h01
`define SFPS_PAGE_BYTES    9'h100
`define SFPS_TXQ_WORDS     4
`define SFPS_TXQ_AW        2
`define SFPS_RST_WORD      32'h0000_0000
`define SFPS_EDGE_SEL      3'h1

`endif

// *** rtl/sfps_seq.sv ***
// Purpose: serial flash page program sequencer, wishbone slave, quad serial link master
// Assumes: link clock sck_i sampled by clk_i; shift on falling sck, flash samples rising
// Notes:   registers at byte offsets in sfps_regs.svh; interrupts on done/rx/txroom
//
// How it works
// - pages are 256 bytes; one program command never carries more than one page
// - instruction 0x02 shifts data on one line, 0x32 on all four lines
// - command word: code in low bits, byte count from bit 16, at most 256
// - transmit buffer drains while shifting; full flag clears when a word frees
// - low-power request is acknowledged only after the active transfer ends
// - status read 0x05 with count one; bit 24 of the received word is flash busy
// - writing bit 16 of the flag register retires the received word
// - write config 0x01 with two bytes from the transmit buffer enables quad mode
// - write-enable instruction code is 0x06
`timescale 1ns/1ps
`include "sfps_regs.svh"

module sfps_seq
    import sfps_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // serial link
    input  wire logic        sck_i,
    output logic             cs_n_o,
    input  wire logic [3:0]  io_i,
    output logic      [3:0]  io_o,
    output logic      [3:0]  io_oe_o,
    // low power handshake
    input  wire logic        lp_req_i,
    output logic             lp_ack_o,
    // interrupt
    output logic             irq_o
);

    // ----------------------------------------------------------------
    // registers and bus decode
    // ----------------------------------------------------------------
    logic [31:0]     addr_q;
    sfps_cmd_type    cmd_q;
    sfps_state_type  state_q;
    logic [31:0]     rx_q;
    logic            rx_ne_q;
    logic [2:0]      irq_st_q;
    logic [2:0]      irq_mask_q;
    logic            lp_ack_q;
    logic            ack_q;
    logic [31:0]     dat_q;
    sfps_status_type st;

    logic req;
    logic wr;
    logic wr_cmd;
    logic wr_tx;
    logic wr_flag;
    logic busy;

    function automatic logic [31:0] lane_mask(input logic [3:0] s);
        lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    assign req     = cyc_i && stb_i && !ack_q;
    assign wr      = req && we_i;
    assign wr_cmd  = wr && adr_i == `SFPS_OFF_CMD && !busy && !go_q && !lp_ack_q;
    assign wr_flag = wr && adr_i == `SFPS_OFF_FLAG;
    assign busy    = state_q != SFPS_IDLE;

    // ----------------------------------------------------------------
    // transmit buffer
    // ----------------------------------------------------------------
    // limitation: a write while full is dropped; software must poll full first
    logic [31:0]                 txq_mem [`SFPS_TXQ_WORDS];
    logic [`SFPS_TXQ_AW:0]       txq_wp_q;
    logic [`SFPS_TXQ_AW:0]       txq_rp_q;
    logic                        txq_full;
    logic                        txq_empty;
    logic                        txq_pop;

    assign txq_full  = (txq_wp_q - txq_rp_q) == (`SFPS_TXQ_AW + 1)'(`SFPS_TXQ_WORDS);
    assign txq_empty = txq_wp_q == txq_rp_q;
    assign wr_tx     = wr && adr_i == `SFPS_OFF_TXPORT && !txq_full;

    always_ff @(posedge clk_i) begin
        if (wr_tx) begin
            txq_mem[txq_wp_q[`SFPS_TXQ_AW-1:0]] <= dat_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txq_wp_q <= '0;
            txq_rp_q <= '0;
        end else begin
            if (wr_tx) begin
                txq_wp_q <= txq_wp_q + 1'b1;
            end
            if (txq_pop) begin
                txq_rp_q <= txq_rp_q + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // link clock sampling
    // ----------------------------------------------------------------
    logic [2:0] sck_q;
    logic [3:0] io_s1_q;
    logic [3:0] io_s2_q;
    logic       sck_fall;
    logic       sck_rise;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sck_q   <= '0;
            io_s1_q <= '0;
            io_s2_q <= '0;
        end else begin
            sck_q   <= {sck_q[1:0], sck_i};
            io_s1_q <= io_i;
            io_s2_q <= io_s1_q;
        end
    end

    assign sck_fall = sck_q[2:1] == 2'b10;
    assign sck_rise = sck_q[2:1] == 2'b01;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    logic [31:0] sh_q;
    logic [5:0]  bits_q;
    logic [8:0]  bytes_q;
    logic [1:0]  wsel_q;
    logic        quad;
    logic        has_data;
    logic        is_read;
    logic        last_bit;
    logic        go_q;

    assign quad     = cmd_q.ins == `SFPS_INS_QPP;
    assign is_read  = cmd_q.ins == `SFPS_INS_RDSR;
    assign has_data = cmd_q.cnt != '0 && !is_read;
    assign last_bit = quad && state_q == SFPS_DAT ? bits_q == 6'd1 : bits_q == 6'd7;
    assign txq_pop  = state_q == SFPS_DAT && sck_fall && last_bit && wsel_q == 2'd3
                      || state_q == SFPS_DAT && sck_fall && last_bit && bytes_q == 9'd1;

    function automatic logic [7:0] tx_byte(input logic [31:0] w, input logic [1:0] s);
        tx_byte = w[8*s +: 8];
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_q <= '0;
            go_q  <= 1'b0;
        end else begin
            // command waits for a link fall so the first rise sees the top bit
            go_q <= wr_cmd || (go_q && !(state_q == SFPS_IDLE && sck_fall));
            if (wr_cmd) begin
                cmd_q.ins <= dat_i[7:0];
                cmd_q.cnt <= dat_i[24:16] > `SFPS_PAGE_BYTES ? `SFPS_PAGE_BYTES
                                                             : dat_i[24:16];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= SFPS_IDLE;
            sh_q    <= '0;
            bits_q  <= '0;
            bytes_q <= '0;
            wsel_q  <= '0;
        end else begin
            unique case (state_q)
                SFPS_IDLE: begin
                    if (go_q && sck_fall) begin
                        state_q <= SFPS_INS;
                        sh_q    <= {cmd_q.ins, 24'h0};
                        bits_q  <= '0;
                        wsel_q  <= '0;
                        bytes_q <= cmd_q.cnt;
                    end
                end
                SFPS_INS: begin
                    if (sck_fall) begin
                        sh_q   <= {sh_q[30:0], 1'b0};
                        bits_q <= bits_q + 6'd1;
                        if (bits_q == 6'd7) begin
                            bits_q <= '0;
                            if (cmd_q.ins == `SFPS_INS_PP || quad) begin
                                state_q <= SFPS_ADR;
                                sh_q    <= {addr_q[23:0], 8'h00};
                                bits_q  <= '0;
                            end else if (is_read) begin
                                state_q <= SFPS_RX;
                                bits_q  <= '0;
                            end else if (has_data && !txq_empty) begin
                                state_q <= SFPS_DAT;
                                sh_q    <= {tx_byte(txq_mem[txq_rp_q[`SFPS_TXQ_AW-1:0]],
                                                    2'd0), 24'h0};
                                bits_q  <= '0;
                            end else begin
                                state_q <= SFPS_DONE;
                            end
                        end
                    end
                end
                SFPS_ADR: begin
                    if (sck_fall) begin
                        sh_q   <= {sh_q[30:0], 1'b0};
                        bits_q <= bits_q + 6'd1;
                        if (bits_q == 6'd23) begin
                            state_q <= has_data ? SFPS_DAT : SFPS_DONE;
                            sh_q    <= {tx_byte(txq_mem[txq_rp_q[`SFPS_TXQ_AW-1:0]],
                                                2'd0), 24'h0};
                            bits_q  <= '0;
                        end
                    end
                end
                SFPS_DAT: begin
                    // stall on an empty buffer keeps the link byte-aligned
                    if (sck_fall && !txq_empty) begin
                        sh_q   <= quad ? {sh_q[27:0], 4'h0} : {sh_q[30:0], 1'b0};
                        bits_q <= bits_q + 6'd1;
                        if (last_bit) begin
                            bits_q  <= '0;
                            bytes_q <= bytes_q - 9'd1;
                            wsel_q  <= wsel_q + 2'd1;
                            if (bytes_q == 9'd1) begin
                                state_q <= SFPS_DONE;
                            end else begin
                                sh_q <= {tx_byte(wsel_q == 2'd3
                                            ? txq_mem[txq_rp_q[`SFPS_TXQ_AW-1:0] + 2'd1]
                                            : txq_mem[txq_rp_q[`SFPS_TXQ_AW-1:0]],
                                          wsel_q + 2'd1), 24'h0};
                            end
                        end
                    end
                end
                SFPS_RX: begin
                    if (sck_rise) begin
                        bits_q <= bits_q + 6'd1;
                        if (bits_q == 6'd7) begin
                            state_q <= SFPS_DONE;
                        end
                    end
                end
                SFPS_DONE: begin
                    if (sck_fall) begin
                        state_q <= SFPS_IDLE;
                    end
                end
                default: begin
                    state_q <= SFPS_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // receive word and flags
    // ----------------------------------------------------------------
    logic rx_done;

    assign rx_done = state_q == SFPS_RX && sck_rise && bits_q == 6'd7;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_q    <= `SFPS_RST_WORD;
            rx_ne_q <= 1'b0;
        end else begin
            if (state_q == SFPS_RX && sck_rise) begin
                rx_q <= {rx_q[30:24], io_s2_q[1], 24'h0};
            end
            if (rx_done) begin
                rx_ne_q <= 1'b1;
            end else if (wr_flag && dat_i[`SFPS_FLAG_RX_BUFFER_NOT_EMPTY_FLAG_BIT]) begin
                rx_ne_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // low power handshake
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lp_ack_q <= 1'b0;
        end else begin
            lp_ack_q <= lp_req_i && !busy && !go_q;
        end
    end

    // ----------------------------------------------------------------
    // serial outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cs_n_o  <= 1'b1;
            io_o    <= '0;
            io_oe_o <= '0;
        end else begin
            cs_n_o  <= !(busy && state_q != SFPS_DONE);
            io_o    <= state_q == SFPS_DAT && quad ? sh_q[31:28] : {3'b000, sh_q[31]};
            io_oe_o <= state_q == SFPS_DAT && quad ? 4'hF
                     : (busy && state_q != SFPS_RX && state_q != SFPS_DONE) ? 4'h1 : 4'h0;
        end
    end

    // ----------------------------------------------------------------
    // interrupts: 0 command done, 1 receive word, 2 transmit room
    // ----------------------------------------------------------------
    logic [2:0] irq_ev;
    logic       busy_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy;
        end
    end

    assign irq_ev = {txq_pop, rx_done, busy_q && !busy};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_st_q   <= '0;
            irq_mask_q <= '0;
        end else begin
            irq_st_q <= (irq_st_q & ~((wr_flag && sel_i[0]) ? dat_i[2:0] : 3'h0)) | irq_ev;
            if (wr && adr_i == `SFPS_OFF_IRQ_MASK && sel_i[0]) begin
                irq_mask_q <= dat_i[2:0];
            end
        end
    end

    assign irq_o = |(irq_st_q & irq_mask_q);

    // ----------------------------------------------------------------
    // address register and bus answer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_q <= `SFPS_RST_WORD;
        end else if (wr && adr_i == `SFPS_OFF_ADDR) begin
            addr_q <= (addr_q & ~lane_mask(sel_i)) | (dat_i & lane_mask(sel_i));
        end
    end

    assign st.lp_ack  = lp_ack_q;
    assign st.rx_ne   = rx_ne_q;
    assign st.tx_full = txq_full;
    assign st.busy    = busy || go_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= req;
            dat_q <= '0;
            if (req && !we_i) begin
                unique case (adr_i)
                    `SFPS_OFF_ADDR:     dat_q <= addr_q;
                    `SFPS_OFF_CMD:      dat_q <= {7'h0, cmd_q.cnt, 8'h0, cmd_q.ins};
                    `SFPS_OFF_RXPORT:   dat_q <= rx_q;
                    `SFPS_OFF_STATUS:   dat_q <= {28'h0, st};
                    `SFPS_OFF_FLAG:     dat_q <= {15'h0, rx_ne_q, 13'h0, irq_st_q};
                    `SFPS_OFF_IRQ_MASK: dat_q <= {29'h0, irq_mask_q};
                    default:            dat_q <= '0;
                endcase
            end
        end
    end

    assign ack_o    = ack_q;
    assign lp_ack_o = lp_ack_q;
    assign dat_o = dat_q;

endmodule

// *** sim/sfps_flash_model.sv ***
// Purpose: behavioural serial flash on the far side of the link
// Assumes: samples on rising sck, shifts out on falling sck
// Notes:   logs every byte seen; bench clears the log before each command whose bytes it checks
`timescale 1ns/1ps
module sfps_flash_model (
    // link
    input  wire logic       sck_i,
    input  wire logic       cs_n_i,
    input  wire logic [3:0] io_o_i,
    input  wire logic [3:0] io_oe_i,
    // flash status byte, set by the bench
    input  wire logic [7:0] sts_i,
    output logic      [3:0] io_i_o
);
    logic [7:0] q[$];
    logic [7:0] sh = 8'h00;
    int         nb = 0;
    logic       so = 1'b0;
    logic       on = 1'b0;
    logic       tg = 1'b0;

    // released lines toggle so a stale value never passes; hold lines pulled up
    assign io_i_o = (io_oe_i & io_o_i) | (~io_oe_i & {2'b11, on ? so : tg, ~tg});

    always @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            nb = 0;
        end else if (q.size() >= 4 && q[0] == 8'h32) begin
            sh = {sh[3:0], io_i_o};
            nb += 4;
            if (nb % 8 == 0) q.push_back(sh);
        end else begin
            sh = {sh[6:0], io_i_o[0]};
            nb += 1;
            if (nb % 8 == 0) q.push_back(sh);
        end
    end

    always @(negedge sck_i or posedge cs_n_i) begin
        tg <= ~tg;
        if (cs_n_i) begin
            on <= 1'b0;
        end else if (q.size() > 0 && q[0] == 8'h05 && nb >= 8) begin
            on <= 1'b1;
            so <= sts_i[7 - ((nb - 8) % 8)];
        end
    end
endmodule

// *** sim/sfps_seq_checker.sv ***
// Purpose: port-level assertions for the page program sequencer
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to sfps_seq at the foot of this file
`timescale 1ns/1ps
`include "sfps_regs.svh"
module sfps_seq_checker (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // wishbone
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // link and misc
    input wire logic        sck_i,
    input wire logic        cs_n_o,
    input wire logic [3:0]  io_i,
    input wire logic [3:0]  io_o,
    input wire logic [3:0]  io_oe_o,
    input wire logic        lp_req_i,
    input wire logic        lp_ack_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_after_req: assert property (
        cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not answered in one cycle");
    a_ack_single_pulse: assert property (
        ack_o |=> !ack_o) else $error("ack longer than one cycle");
    a_ack_has_cause: assert property (
        ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
    a_ack_idle_bus: assert property (
        !cyc_i |=> !ack_o) else $error("ack on idle bus");
    a_unmapped_zero: assert property (
        ack_o && $past(!we_i && adr_i == `SFPS_OFF_LP_CTRL) |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_oe_needs_select: assert property (
        io_oe_o != 4'h0 |-> !cs_n_o) else $error("lines driven while deselected");
    a_oe_lane_mode: assert property (
        io_oe_o inside {4'h0, 4'h1, 4'hF}) else $error("neither single nor quad lanes");
    a_frame_min_len: assert property (
        $fell(cs_n_o) |=> !cs_n_o [*8]) else $error("frame ended too early");
endmodule

bind sfps_seq sfps_seq_checker chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .sck_i(sck_i), .cs_n_o(cs_n_o), .io_i(io_i),
    .io_o(io_o), .io_oe_o(io_oe_o), .lp_req_i(lp_req_i), .lp_ack_o(lp_ack_o),
    .irq_o(irq_o));

// *** sim/sfps_seq_tb.sv ***
// Purpose: self-checking bench for the page program sequencer
// Assumes: sck runs at 160 ns only while a command is in flight
// Notes:   random data and addresses from seed 3
`timescale 1ns/1ps
`include "sfps_regs.svh"
module sfps_seq_tb
    import sfps_pkg::*;
;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic        sck_i = 0, lp_req_i = 0, lk_en = 0, ack_o, cs_n_o, lp_ack_o, irq_o;
    logic [7:0]  adr_i = 8'h00, sts = 8'h00, ex[$];
    logic [3:0]  sel_i = 4'h0, io_i, io_o, io_oe_o;
    logic [31:0] dat_i = 32'h0, dat_o, rd, a, w[64];
    int          err_total = 0, comparisons = 0, nw;

    always #10 clk_i = ~clk_i;
    initial begin
        #7;
        forever begin
            #80;
            // link clock always comes to rest low
            if (lk_en || sck_i) sck_i = ~sck_i;
        end
    end

    sfps_seq uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .sck_i(sck_i), .cs_n_o(cs_n_o), .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o),
        .lp_req_i(lp_req_i), .lp_ack_o(lp_ack_o), .irq_o(irq_o));
    sfps_flash_model fl (.sck_i(sck_i), .cs_n_i(cs_n_o), .io_o_i(io_o), .io_oe_i(io_oe_o),
        .sts_i(sts), .io_i_o(io_i));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, wr, ad, d, 4'hF};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 20) chk("ack", 1, 0);
    endtask

    // no fixed latency assumed: poll a status bit under a bound
    task automatic poll(input int b, input logic v);
        int n;
        n = 0;
        do begin
            wb(0, `SFPS_OFF_STATUS, 0);
            n++;
        end while (rd[b] !== v && n < 5000);
        if (n >= 5000) chk("poll", v, ~v);
    endtask

    task automatic run(input logic [31:0] c);
        lk_en = 1;
        wb(1, `SFPS_OFF_CMD, c);
        poll(`SFPS_ST_BUSY_BIT, 0);
        lk_en = 0;
    endtask

    task automatic cmp_log();
        chk("bytes", ex.size(), fl.q.size());
        foreach (ex[i]) if (i < fl.q.size()) chk("byte", ex[i], fl.q[i]);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #1_500_000;
        chk("watchdog", 0, 1);
        print_verdict();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(3));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, `SFPS_OFF_STATUS, 0);
        chk("status_rst", 0, rd[3:0]);
        wb(0, `SFPS_OFF_LP_CTRL, 0);
        chk("unmapped", 0, rd);
        for (int k = 0; k < 4; k++) begin
            a = $urandom & 32'h00FF_FFFF;
            nw = (k == 3) ? 64 : 1 + $urandom % 16;
            wb(1, `SFPS_OFF_ADDR, a);
            fl.q.delete();
            run(32'h0000_0006);
            chk("wren", 8'h06, fl.q[0]);
            fl.q.delete();
            ex = {k[0] ? 8'h32 : 8'h02, a[23:16], a[15:8], a[7:0]};
            for (int i = 0; i < nw; i++) begin
                w[i] = $urandom;
                ex = {ex, w[i][7:0], w[i][15:8], w[i][23:16], w[i][31:24]};
                if (i < 4) wb(1, `SFPS_OFF_TXPORT, w[i]);
            end
            lk_en = 1;
            wb(1, `SFPS_OFF_CMD, {7'h00, 9'(nw * 4), 8'h00, ex[0]});
            for (int i = 4; i < nw; i++) begin
                poll(`SFPS_ST_TX_BUFFER_FULL_FLAG_BIT, 0);
                wb(1, `SFPS_OFF_TXPORT, w[i]);
            end
            poll(`SFPS_ST_BUSY_BIT, 0);
            lk_en = 0;
            cmp_log();
        end
        for (int k = 0; k < 2; k++) begin
            sts = ($urandom & 8'hFE) | 8'(k);
            fl.q.delete();
            run(32'h0001_0005);
            poll(`SFPS_ST_RX_BUFFER_NOT_EMPTY_FLAG_BIT, 1);
            wb(0, `SFPS_OFF_RXPORT, 0);
            chk("flash_busy", sts[0], rd[24]);
            wb(1, `SFPS_OFF_FLAG, 32'h0001_0000);
            wb(0, `SFPS_OFF_STATUS, 0);
            chk("rx_retire", 0, rd[2]);
        end
        run(32'h0000_0006);
        fl.q.delete();
        a = $urandom;
        wb(1, `SFPS_OFF_TXPORT, a);
        run(32'h0002_0001);
        ex = {8'h01, a[7:0], a[15:8]};
        cmp_log();
        wb(1, `SFPS_OFF_IRQ_MASK, 0);
        wb(1, `SFPS_OFF_FLAG, 32'h0000_0007);
        run(32'h0000_0006);
        repeat (2) @(posedge clk_i);
        chk("irq_masked", 0, irq_o);
        wb(1, `SFPS_OFF_IRQ_MASK, 1);
        repeat (2) @(posedge clk_i);
        chk("irq_done", 1, irq_o);
        wb(1, `SFPS_OFF_FLAG, 1);
        repeat (2) @(posedge clk_i);
        chk("irq_clear", 0, irq_o);
        lk_en = 1;
        wb(1, `SFPS_OFF_CMD, 32'h0000_0006);
        lp_req_i <= 1'b1;
        wb(0, `SFPS_OFF_STATUS, 0);
        chk("lp_wait", 2'b01, {rd[3], rd[0]});
        poll(`SFPS_ST_LPACK_BIT, 1);
        chk("lp_after", 0, rd[0]);
        chk("lp_ack_pin", 1, lp_ack_o);
        lp_req_i <= 1'b0;
        lk_en = 0;
        print_verdict();
    end
endmodule
